// ---- include/spi_port_cfg_pkg.sv ----
// Purpose: constants and carriers for the serial port configuration block
// Assumes: instruction word is r/w, two-bit length, 13-bit register address
// Notes: behaviour list follows
// Behaviour
// - config bit 7 clear: data pin both ways, dedicated output released.
// - config bit 7 set: writes on data pin, reads on dedicated output.
// - config bit 6 clear: msb first, address decrements per byte.
// - config bit 6 set: lsb first, address increments per byte.
// - bit order and address direction ignored while in i2c mode.
// - writing one to config bit 5 restores internal registers to defaults.
// - soft reset bit clears itself on the next serial clock after the write.
// - soft reset leaves the configuration register itself unchanged.
// - read-only revision register at address 0x002.
// - read-only fixed variant code register at address 0x003.
// - readback_source_select bit 0 selects buffered (clear) or active (set) readback.
package spi_port_cfg_pkg;
   localparam int ADDR_W = 13;
   localparam logic [ADDR_W-1:0] ADDR_CONFIG = 13'h0000;
   localparam logic [ADDR_W-1:0] ADDR_REVISION = 13'h0002;
   localparam logic [ADDR_W-1:0] ADDR_VARIANT = 13'h0003;
   localparam logic [ADDR_W-1:0] ADDR_READBACK = 13'h0004;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] READBACK_RESET = 8'h00;
   localparam logic [7:0] REVISION_DEFAULT = 8'h5a; // arbitrary value
   localparam logic [7:0] VARIANT_DEFAULT = 8'h3c; // arbitrary value
   localparam int READBACK_SEL_BIT = 0;
   localparam logic [3:0] INSTR_BITS = 4'hf;
   localparam logic [3:0] DATA_BITS = 4'h7;
   localparam logic [1:0] LEN_STREAM = 2'h3;

   typedef struct packed {
      logic four_wire_select;
      logic lsb_first;
      logic soft_reset;
      logic unused;
      logic [3:0] mirror;
   } spi_cfg_type;

   typedef struct packed {
      logic read;
      logic [1:0] length;
      logic [ADDR_W-1:0] addr;
   } instr_type;

   typedef enum logic [2:0] {
      ST_INSTR = 3'h1,
      ST_DATA = 3'h2,
      ST_DONE = 3'h4
   } frame_state_type;
endpackage : spi_port_cfg_pkg

// ---- logic/serial_port_config_regs.sv ----
// Purpose: spi-mode serial port configuration and identification registers
// Assumes: host drives i_sclk only inside frames; cs low frames a transfer
// Notes: buffered registers live on i_sclk, active copies on i_ref_clk
`timescale 1ns/1ps
module serial_port_config_regs #(
   parameter logic [7:0] REVISION_CODE = spi_port_cfg_pkg::REVISION_DEFAULT,
   parameter logic [7:0] VARIANT_CODE = spi_port_cfg_pkg::VARIANT_DEFAULT
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_io_update,
   input wire logic i_i2c_mode,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_sdio,
   output logic o_sdio,
   output logic o_sdio_oe,
   output logic o_dedicated_serial_out_pin,
   output logic o_dedicated_serial_out_pin_oe,
   output logic o_soft_reset,
   output logic o_readback_active_copy
);
   // ---------------- link domain ----------------
   spi_port_cfg_pkg::spi_cfg_type cfg_reg;
   spi_port_cfg_pkg::spi_cfg_type cfg_next;
   logic [7:0] rb_buf_reg;
   logic [7:0] rb_buf_next;
   spi_port_cfg_pkg::frame_state_type state_reg;
   spi_port_cfg_pkg::frame_state_type state_next;
   spi_port_cfg_pkg::instr_type instr_reg;
   spi_port_cfg_pkg::instr_type instr_word;
   logic [15:0] shift_reg;
   logic [15:0] shift_next;
   logic [3:0] bit_cnt_reg;
   logic [3:0] bit_cnt_next;
   logic [1:0] bytes_left_reg;
   logic [1:0] bytes_left_next;
   logic [spi_port_cfg_pkg::ADDR_W-1:0] addr_reg;
   logic [spi_port_cfg_pkg::ADDR_W-1:0] addr_next;
   logic [spi_port_cfg_pkg::ADDR_W-1:0] addr_step;
   logic [7:0] tx_reg;
   logic [7:0] tx_next;
   logic out_bit_reg;
   logic i2c_meta_reg;
   logic i2c_sync_reg;
   logic act_meta_reg;
   logic act_sync_reg;
   logic frame_rst_n;
   logic lsb_eff;
   logic incr_eff;
   logic instr_end;
   logic byte_end;
   logic write_byte;
   logic [7:0] rx_byte;
   logic [7:0] rd_mux;
   logic [7:0] rb_rd_value;
   logic [spi_port_cfg_pkg::ADDR_W-1:0] rd_addr;
   logic [2:0] out_idx;
   logic reading;
   logic more_bytes;

   // frame logic restarts whenever chip select is released
   assign frame_rst_n = i_reset_n & ~i_cs_n;

   assign lsb_eff = cfg_reg.lsb_first & ~i2c_sync_reg;
   assign incr_eff = cfg_reg.lsb_first | i2c_sync_reg;

   // both orders land in the same msb-first view of the word
   assign shift_next = lsb_eff ?
      {i_sdio, shift_reg[15:1]} :
      {shift_reg[14:0], i_sdio};
   assign rx_byte = lsb_eff ? shift_next[15:8] : shift_next[7:0];
   assign instr_word = spi_port_cfg_pkg::instr_type'(shift_next);

   assign instr_end = (state_reg == spi_port_cfg_pkg::ST_INSTR) &&
      (bit_cnt_reg == spi_port_cfg_pkg::INSTR_BITS);
   assign byte_end = (state_reg == spi_port_cfg_pkg::ST_DATA) &&
      (bit_cnt_reg == spi_port_cfg_pkg::DATA_BITS);
   assign write_byte = byte_end & ~instr_reg.read;
   assign more_bytes = (instr_reg.length == spi_port_cfg_pkg::LEN_STREAM) ||
      (bytes_left_reg != 2'h0);

   assign addr_step = incr_eff ?
      addr_reg + 13'h0001 :
      addr_reg - 13'h0001;

   assign bit_cnt_next = (instr_end || byte_end) ? 4'h0 :
      bit_cnt_reg + 4'h1;

   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      bytes_left_next = bytes_left_reg;
      if (instr_end) begin
         state_next = spi_port_cfg_pkg::ST_DATA;
         addr_next = instr_word.addr;
         bytes_left_next = instr_word.length;
      end else if (byte_end) begin
         addr_next = addr_step;
         if (more_bytes) begin
            bytes_left_next = bytes_left_reg - 2'h1;
         end else begin
            state_next = spi_port_cfg_pkg::ST_DONE;
         end
      end
   end

   // readback selection; the select itself is taken from the buffered copy
   assign rb_rd_value = rb_buf_reg[spi_port_cfg_pkg::READBACK_SEL_BIT] ?
      {7'h00, act_sync_reg} : rb_buf_reg;
   assign rd_addr = instr_end ? instr_word.addr : addr_step;
   assign rd_mux =
      (rd_addr == spi_port_cfg_pkg::ADDR_CONFIG) ? cfg_reg :
      (rd_addr == spi_port_cfg_pkg::ADDR_REVISION) ? REVISION_CODE :
      (rd_addr == spi_port_cfg_pkg::ADDR_VARIANT) ? VARIANT_CODE :
      (rd_addr == spi_port_cfg_pkg::ADDR_READBACK) ? rb_rd_value :
      8'h00;
   assign tx_next = (instr_end || byte_end) ? rd_mux : tx_reg;

   // register writes; revision and variant addresses ignore writes
   always_comb begin
      cfg_next = cfg_reg;
      rb_buf_next = rb_buf_reg;
      if (cfg_reg.soft_reset) begin
         cfg_next.soft_reset = 1'b0;
         rb_buf_next = spi_port_cfg_pkg::READBACK_RESET;
      end
      if (write_byte) begin
         if (addr_reg == spi_port_cfg_pkg::ADDR_CONFIG) begin
            cfg_next = spi_port_cfg_pkg::spi_cfg_type'(rx_byte);
         end
         if (addr_reg == spi_port_cfg_pkg::ADDR_READBACK) begin
            rb_buf_next = rx_byte;
         end
      end
   end

   always_ff @(posedge i_sclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_reg <= spi_port_cfg_pkg::CONFIG_RESET;
         rb_buf_reg <= spi_port_cfg_pkg::READBACK_RESET;
      end else begin
         cfg_reg <= cfg_next;
         rb_buf_reg <= rb_buf_next;
      end
   end

   always_ff @(posedge i_sclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         i2c_meta_reg <= 1'b0;
         i2c_sync_reg <= 1'b0;
         act_meta_reg <= 1'b0;
         act_sync_reg <= 1'b0;
      end else begin
         i2c_meta_reg <= i_i2c_mode;
         i2c_sync_reg <= i2c_meta_reg;
         act_meta_reg <= o_readback_active_copy;
         act_sync_reg <= act_meta_reg;
      end
   end

   always_ff @(posedge i_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         state_reg <= spi_port_cfg_pkg::ST_INSTR;
         instr_reg <= '0;
         shift_reg <= 16'h0000;
         bit_cnt_reg <= 4'h0;
         bytes_left_reg <= 2'h0;
         addr_reg <= '0;
         tx_reg <= 8'h00;
      end else if (state_reg != spi_port_cfg_pkg::ST_DONE) begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         bit_cnt_reg <= bit_cnt_next;
         bytes_left_reg <= bytes_left_next;
         addr_reg <= addr_next;
         tx_reg <= tx_next;
         if (instr_end) begin
            instr_reg <= instr_word;
         end
      end
   end

   // read data changes on the falling edge so the host samples it rising
   assign out_idx = lsb_eff ? bit_cnt_reg[2:0] : 3'h7 - bit_cnt_reg[2:0];

   always_ff @(negedge i_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         out_bit_reg <= 1'b0;
      end else begin
         out_bit_reg <= tx_reg[out_idx];
      end
   end

   assign reading = (state_reg == spi_port_cfg_pkg::ST_DATA) &&
      instr_reg.read && !i_cs_n;
   assign o_sdio = out_bit_reg;
   assign o_sdio_oe = reading & ~cfg_reg.four_wire_select;
   assign o_dedicated_serial_out_pin = out_bit_reg;
   assign o_dedicated_serial_out_pin_oe =
      reading & cfg_reg.four_wire_select;

   // ---------------- reference domain ----------------
   // limitation: the buffered select crosses as a quasi-static level, so
   // software should let it settle before pulsing the update pin
   logic soft_meta_reg;
   logic soft_sync_reg;
   logic upd_meta_reg;
   logic upd_sync_reg;
   logic upd_prev_reg;
   logic buf_meta_reg;
   logic buf_sync_reg;
   logic active_next;
   logic upd_rise;

   assign upd_rise = upd_sync_reg & ~upd_prev_reg;
   assign active_next = soft_sync_reg ? 1'b0 :
      upd_rise ? buf_sync_reg : o_readback_active_copy;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         soft_meta_reg <= 1'b0;
         soft_sync_reg <= 1'b0;
         upd_meta_reg <= 1'b0;
         upd_sync_reg <= 1'b0;
         upd_prev_reg <= 1'b0;
         buf_meta_reg <= 1'b0;
         buf_sync_reg <= 1'b0;
         o_readback_active_copy <= 1'b0;
      end else begin
         soft_meta_reg <= cfg_reg.soft_reset;
         soft_sync_reg <= soft_meta_reg;
         upd_meta_reg <= i_io_update;
         upd_sync_reg <= upd_meta_reg;
         upd_prev_reg <= upd_sync_reg;
         buf_meta_reg <= rb_buf_reg[spi_port_cfg_pkg::READBACK_SEL_BIT];
         buf_sync_reg <= buf_meta_reg;
         o_readback_active_copy <= active_next;
      end
   end

   assign o_soft_reset = soft_sync_reg;
endmodule : serial_port_config_regs

// ---- verification/serial_port_config_regs_monitor.sv ----
// Purpose: port checks of the serial port configuration block
// Assumes: reads of one or two bytes; cs high between frames
// Notes: edge count restarts while cs is high
`timescale 1ns/1ps
module serial_port_config_regs_monitor (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_io_update,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic o_sdio,
   input wire logic o_sdio_oe,
   input wire logic o_dedicated_serial_out_pin,
   input wire logic o_dedicated_serial_out_pin_oe,
   input wire logic o_soft_reset,
   input wire logic o_readback_active_copy
);
   logic [5:0] cnt_reg;
   logic any_oe;
   assign any_oe = o_sdio_oe | o_dedicated_serial_out_pin_oe;
   always_ff @(posedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) cnt_reg <= 6'h00;
      else cnt_reg <= cnt_reg + 6'h01;
   end
   sequence s_hold8(sig);
      sig [*8];
   endsequence
   property p_sdio8;
      @(posedge i_sclk) disable iff (!i_reset_n || i_cs_n)
         $rose(o_sdio_oe) |-> s_hold8(o_sdio_oe);
   endproperty
   a_sdio8: assert property (p_sdio8) else $error("sdio short");
   property p_ded8;
      @(posedge i_sclk) disable iff (!i_reset_n || i_cs_n)
         $rose(o_dedicated_serial_out_pin_oe) |->
         s_hold8(o_dedicated_serial_out_pin_oe);
   endproperty
   a_ded8: assert property (p_ded8) else $error("out pin short");
   property p_quiet;
      @(posedge i_sclk) disable iff (!i_reset_n || i_cs_n)
         any_oe |-> cnt_reg >= 6'h10 && cnt_reg < 6'h20;
   endproperty
   a_quiet: assert property (p_quiet) else $error("early drive");
   property p_same;
      @(posedge i_sclk) disable iff (!i_reset_n || i_cs_n)
         any_oe |-> o_sdio == o_dedicated_serial_out_pin;
   endproperty
   a_same: assert property (p_same) else $error("bit differs");
   property p_idle;
      @(posedge i_ref_clk) disable iff (!i_reset_n) i_cs_n |-> !any_oe;
   endproperty
   a_idle: assert property (p_idle) else $error("idle drive");
   property p_one;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         !(o_sdio_oe && o_dedicated_serial_out_pin_oe);
   endproperty
   a_one: assert property (p_one) else $error("two drivers");
   property p_soft;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         o_soft_reset |-> ##[1:3] !o_readback_active_copy;
   endproperty
   a_soft: assert property (p_soft) else $error("active kept");
   property p_cause;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         $changed(o_readback_active_copy) |-> $past(i_io_update, 2) ||
         $past(i_io_update, 3) || $past(o_soft_reset, 2) || o_soft_reset;
   endproperty
   a_cause: assert property (p_cause) else $error("stray change");
endmodule : serial_port_config_regs_monitor
bind serial_port_config_regs serial_port_config_regs_monitor
   serial_port_config_regs_monitor_i (.*);

// ---- verification/spi_host_model.sv ----
// Purpose: spi host making frames on its own link clock
// Assumes: one or two data bytes a frame
// Notes: clock stands still between frames; a released line flips
`timescale 1ns/1ps
module spi_host_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_data,
   input wire logic i_sdio_line,
   input wire logic i_out_pin,
   input wire logic i_out_pin_oe
);
   logic drv = 1'b0;
   logic dbit = 1'b0;
   logic junk = 1'b0;
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      forever #7 junk = ~junk;
   end
   assign o_data = drv ? dbit : junk;
   task automatic xfer(input logic rd, input int nb, input logic lsb,
         input logic four, input logic [12:0] a, input logic [15:0] wd,
         output logic [15:0] q);
      logic [15:0] ins;
      int j;
      int k;
      ins = {rd, 2'(nb - 1), a};
      q = 16'h0000;
      o_cs_n = 1'b0;
      for (int i = 0; i < 16 + 8 * nb; i++) begin
         j = i - 16;
         k = 8 * (1 - j / 8) + (lsb ? j % 8 : 7 - j % 8);
         drv = !(rd && i > 15);
         dbit = (i < 16) ? ins[lsb ? i : 15 - i] : wd[k];
         #24 o_sclk = 1'b1;
         if (i > 15) q[k] = four ? (i_out_pin_oe ? i_out_pin : junk)
            : i_sdio_line;
         #24 o_sclk = 1'b0;
      end
      #24 o_cs_n = 1'b1;
      drv = 1'b0;
      #48;
   endtask : xfer
endmodule : spi_host_model

// ---- verification/tb.sv ----
// Purpose: self-checking bench of the serial port configuration block
// Assumes: host model frames on a 48 ns link clock; ref clock 100 ns
// Notes: expected bytes come from package codes and written values
`timescale 1ns/1ps
module tb;
   logic i_ref_clk, i_reset_n, i_io_update, i_i2c_mode, i_sclk, i_cs_n;
   logic i_sdio, h_data, o_sdio, o_sdio_oe, o_soft_reset, v, pa;
   logic o_dedicated_serial_out_pin, o_dedicated_serial_out_pin_oe;
   logic o_readback_active_copy;
   logic [7:0] cfg, x;
   logic [15:0] q;
   int num_errors, n_compared;
   localparam logic [7:0] REV = spi_port_cfg_pkg::REVISION_DEFAULT;
   localparam logic [7:0] IDC = spi_port_cfg_pkg::VARIANT_DEFAULT;
   assign i_sdio = o_sdio_oe ? o_sdio : h_data;
   serial_port_config_regs serial_port_config_regs_i (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_io_update(i_io_update),
      .i_i2c_mode(i_i2c_mode),
      .i_sclk(i_sclk),
      .i_cs_n(i_cs_n),
      .i_sdio(i_sdio),
      .o_sdio(o_sdio),
      .o_sdio_oe(o_sdio_oe),
      .o_dedicated_serial_out_pin(o_dedicated_serial_out_pin),
      .o_dedicated_serial_out_pin_oe(o_dedicated_serial_out_pin_oe),
      .o_soft_reset(o_soft_reset),
      .o_readback_active_copy(o_readback_active_copy));
   spi_host_model spi_host_model_i (.o_sclk(i_sclk), .o_cs_n(i_cs_n),
      .o_data(h_data), .i_sdio_line(i_sdio),
      .i_out_pin(o_dedicated_serial_out_pin),
      .i_out_pin_oe(o_dedicated_serial_out_pin_oe));
   initial begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end
   function automatic logic [7:0] mir(logic [3:0] h);
      return {h, h[0], h[1], h[2], h[3]};
   endfunction : mir
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic xf(input logic r, input int n, input logic [12:0] a,
         input logic [15:0] d);
      spi_host_model_i.xfer(r, n, cfg[6] && !i_i2c_mode, cfg[7], a, d, q);
   endtask : xf
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   initial begin
      #4000000;
      num_errors++;
      close_out();
   end
   initial begin
      {i_reset_n, i_io_update, i_i2c_mode, pa} = 4'h0;
      cfg = 8'h00;
      void'($urandom(83108));
      repeat (16) @(negedge i_ref_clk);
      i_reset_n = 1'b1;
      xf(1'b1, 1, 13'h1fff, 16'h0000);
      xf(1'b1, 1, 13'h0000, 16'h0000);
      chk(q, 16'h0000);
      xf(1'b0, 1, 13'h0003, {8'($urandom), 8'h00});
      xf(1'b1, 2, 13'h0003, 16'h0000);
      chk(q, {IDC, REV});
      for (int m = 0; m < 4; m++) begin
         x = mir({2'(m), 2'b00});
         xf(1'b0, 1, 13'h0000, {x, 8'h00});
         cfg = x;
         xf(1'b1, 1, 13'h0000, 16'h0000);
         chk(q, {x, 8'h00});
         xf(1'b1, 2, cfg[6] ? 13'h0002 : 13'h0003, 16'h0000);
         chk(q, cfg[6] ? {REV, IDC} : {IDC, REV});
      end
      for (int i = 0; i < 5; i++) begin
         v = (i < 2 || i == 4) ? 1'b1 : 1'($urandom);
         xf(1'b0, 1, 13'h0004, {7'h00, v, 8'h00});
         xf(1'b1, 1, 13'h0004, 16'h0000);
         chk(q, {7'h00, v & pa, 8'h00});
         @(negedge i_ref_clk) i_io_update = 1'b1;
         repeat (6) @(negedge i_ref_clk);
         i_io_update = 1'b0;
         repeat (6) @(negedge i_ref_clk);
         pa = v;
         chk({15'h0000, o_readback_active_copy}, {15'h0000, v});
         xf(1'b1, 1, 13'h0004, 16'h0000);
         chk(q, {7'h00, v, 8'h00});
      end
      x = mir({cfg[7:6], 2'b10});
      xf(1'b0, 1, 13'h0000, {x, 8'h00});
      repeat (8) @(negedge i_ref_clk);
      chk({15'h0000, o_readback_active_copy}, 16'h0000);
      xf(1'b1, 1, 13'h0000, 16'h0000);
      chk(q, {x & 8'hdf, 8'h00});
      xf(1'b1, 1, 13'h0004, 16'h0000);
      chk(q, 16'h0000);
      @(negedge i_ref_clk) i_i2c_mode = 1'b1;
      xf(1'b1, 1, 13'h1fff, 16'h0000);
      xf(1'b1, 2, 13'h0002, 16'h0000);
      chk(q, {REV, IDC});
      // mid-run reset must drop both the select and the configuration
      xf(1'b0, 1, 13'h0004, 16'h0100);
      @(negedge i_ref_clk) i_reset_n = 1'b0;
      repeat (4) @(negedge i_ref_clk);
      i_reset_n = 1'b1;
      cfg = spi_port_cfg_pkg::CONFIG_RESET;
      xf(1'b1, 1, 13'h0004, 16'h0000);
      chk(q, {spi_port_cfg_pkg::READBACK_RESET, 8'h00});
      xf(1'b1, 1, 13'h0000, 16'h0000);
      chk(q, {spi_port_cfg_pkg::CONFIG_RESET, 8'h00});
      close_out();
   end
endmodule : tb
